// ### rtl/fsps_top.sv
`timescale 1ns/1ns
// How it works
// - One erase request erases exactly the one page holding the target address.
// - One program request always carries exactly two instruction words together.
// - No operation starts unless the full unlock sequence preceded the start write.
// - Core stays stalled from launch until the flash reports the operation done.
// - Writing one to control bit 15 launches the selected erase or program.
// - Hardware clears the start bit itself when the operation finishes.
// - Unlock needs 0x55 then 0xAA in consecutive writes; it is never read.
// - Target address is 24 bits: upper 8-bit register joined to lower 16-bit.
`include "fsps_regs.svh"

module fsps_top
    import fsps_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire fsps_sw_wr_t i_sw_wr,
    input wire fsps_word_pair_t i_prog_words,
    input wire logic i_flash_done,
    output fsps_flash_req_t o_flash_req,
    output logic o_core_stall,
    output logic [15:0] o_ctrl_rd
);

    // ************************************************
    // Reset release
    // ************************************************

    logic rst_meta_reg;
    logic rst_sync_b_reg;

    // Two flops release the reset on the clock
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta_reg <= 1'b0;
            rst_sync_b_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_b_reg <= rst_meta_reg;
        end
    end

    // ************************************************
    // Software registers
    // ************************************************

    fsps_state_t state_reg;
    fsps_key_t key_reg;
    logic start_reg;
    logic erase_sel_reg;
    logic [`FSPS_ADDR_HI_W-1:0] addr_hi_reg;
    logic [`FSPS_ADDR_LO_W-1:0] addr_lo_reg;
    logic ctrl_wr;
    logic launch;
    logic busy;
    logic op_done;

    assign busy = start_reg;
    // The array's done only counts while an operation is outstanding
    assign op_done = (state_reg == FSPS_WAIT) && i_flash_done;
    assign ctrl_wr = i_sw_wr.wr_en && (i_sw_wr.sel == `FSPS_SEL_CTRL);
    // Launch only when unlocked, idle and start bit written as one
    assign launch = ctrl_wr && i_sw_wr.data[`FSPS_CTRL_START_BIT]
                    && (key_reg == FSPS_KEY_ARMED) && !busy;

    // Unlock key tracking; any other write breaks the sequence
    always_ff @(posedge i_ref_clk or negedge rst_sync_b_reg) begin
        if (!rst_sync_b_reg) begin
            key_reg <= FSPS_KEY_NONE;
        end else if (i_sw_wr.wr_en) begin
            if (i_sw_wr.sel == `FSPS_SEL_UNLOCK && i_sw_wr.data == `FSPS_KEY_FIRST) begin
                key_reg <= FSPS_KEY_HALF;
            end else if (i_sw_wr.sel == `FSPS_SEL_UNLOCK && i_sw_wr.data == `FSPS_KEY_SECOND
                         && key_reg == FSPS_KEY_HALF) begin
                key_reg <= FSPS_KEY_ARMED;
            end else begin
                key_reg <= FSPS_KEY_NONE;
            end
        end
    end

    // Operation select and address, frozen while busy
    always_ff @(posedge i_ref_clk or negedge rst_sync_b_reg) begin
        if (!rst_sync_b_reg) begin
            erase_sel_reg <= 1'b0;
            addr_hi_reg <= '0;
            addr_lo_reg <= '0;
        end else if (i_sw_wr.wr_en && !busy) begin
            if (i_sw_wr.sel == `FSPS_SEL_CTRL) begin
                erase_sel_reg <= i_sw_wr.data[`FSPS_CTRL_ERASE_BIT];
            end
            if (i_sw_wr.sel == `FSPS_SEL_ADDR_HI) begin
                addr_hi_reg <= i_sw_wr.data[`FSPS_ADDR_HI_W-1:0];
            end
            if (i_sw_wr.sel == `FSPS_SEL_ADDR_LO) begin
                addr_lo_reg <= i_sw_wr.data;
            end
        end
    end

    // ************************************************
    // Sequencer
    // ************************************************

    // Idle, one issue cycle, then wait for the array
    always_ff @(posedge i_ref_clk or negedge rst_sync_b_reg) begin
        if (!rst_sync_b_reg) begin
            state_reg <= FSPS_IDLE;
        end else begin
            unique case (state_reg)
                FSPS_IDLE: begin
                    if (launch) begin
                        state_reg <= FSPS_ISSUE;
                    end
                end
                FSPS_ISSUE: begin
                    state_reg <= FSPS_WAIT;
                end
                FSPS_WAIT: begin
                    if (i_flash_done) begin
                        state_reg <= FSPS_IDLE;
                    end
                end
                default: begin
                    state_reg <= FSPS_IDLE;
                end
            endcase
        end
    end

    // Start bit and core stall set on launch, cleared on completion
    always_ff @(posedge i_ref_clk or negedge rst_sync_b_reg) begin
        if (!rst_sync_b_reg) begin
            start_reg <= 1'b0;
            o_core_stall <= 1'b0;
        end else if (launch) begin
            start_reg <= 1'b1;
            o_core_stall <= 1'b1;
        end else if (op_done) begin
            start_reg <= 1'b0;
            o_core_stall <= 1'b0;
        end
    end

    // One-cycle request to the array with address and word pair
    always_ff @(posedge i_ref_clk or negedge rst_sync_b_reg) begin
        if (!rst_sync_b_reg) begin
            o_flash_req <= '0;
        end else begin
            o_flash_req.valid <= launch;
            if (launch) begin
                o_flash_req.erase <= i_sw_wr.data[`FSPS_CTRL_ERASE_BIT];
                o_flash_req.addr <= {addr_hi_reg, addr_lo_reg};
                o_flash_req.words <= i_prog_words;
            end
        end
    end

    // Control readback: start bit and operation select
    // Start readback clears on the same edge as the stall, so a released core never reads busy
    always_ff @(posedge i_ref_clk or negedge rst_sync_b_reg) begin
        if (!rst_sync_b_reg) begin
            o_ctrl_rd <= `FSPS_CTRL_RESET;
        end else begin
            o_ctrl_rd <= {(start_reg && !op_done) || launch, 14'h0000,
                          launch ? i_sw_wr.data[`FSPS_CTRL_ERASE_BIT] : erase_sel_reg};
        end
    end

    // ************************************************
    // Checks
    // ************************************************

    property p_erase_one_page;
        @(posedge i_ref_clk) disable iff (!rst_sync_b_reg)
        launch && i_sw_wr.data[`FSPS_CTRL_ERASE_BIT] |=> o_flash_req.valid && o_flash_req.erase;
    endproperty
    a_erase_one_page: assert property (p_erase_one_page) else $error("erase not issued");

    property p_word_pair;
        @(posedge i_ref_clk) disable iff (!rst_sync_b_reg)
        launch |=> o_flash_req.words == $past(i_prog_words);
    endproperty
    a_word_pair: assert property (p_word_pair) else $error("word pair not carried");

    property p_needs_unlock;
        @(posedge i_ref_clk) disable iff (!rst_sync_b_reg)
        $rose(start_reg) |-> $past(key_reg) == FSPS_KEY_ARMED;
    endproperty
    a_needs_unlock: assert property (p_needs_unlock) else $error("start without unlock");

    property p_stall_held;
        @(posedge i_ref_clk) disable iff (!rst_sync_b_reg)
        state_reg != FSPS_IDLE |-> o_core_stall;
    endproperty
    a_stall_held: assert property (p_stall_held) else $error("stall dropped early");

    property p_stall_release;
        @(posedge i_ref_clk) disable iff (!rst_sync_b_reg)
        $fell(o_core_stall) |-> $past(state_reg) == FSPS_WAIT && $past(i_flash_done);
    endproperty
    a_stall_release: assert property (p_stall_release) else $error("stall released without done");

    property p_start_launch;
        @(posedge i_ref_clk) disable iff (!rst_sync_b_reg)
        launch |=> start_reg && o_flash_req.valid ##1 !o_flash_req.valid;
    endproperty
    a_start_launch: assert property (p_start_launch) else $error("launch did not start");

    property p_auto_clear;
        @(posedge i_ref_clk) disable iff (!rst_sync_b_reg)
        state_reg == FSPS_WAIT && i_flash_done |=> !start_reg && !o_core_stall && !o_ctrl_rd[15];
    endproperty
    a_auto_clear: assert property (p_auto_clear) else $error("start bit not cleared");

    property p_addr_join;
        @(posedge i_ref_clk) disable iff (!rst_sync_b_reg)
        launch |=> o_flash_req.addr == {$past(addr_hi_reg), $past(addr_lo_reg)};
    endproperty
    a_addr_join: assert property (p_addr_join) else $error("address not joined");

    property p_busy_ignore;
        @(posedge i_ref_clk) disable iff (!rst_sync_b_reg)
        start_reg && ctrl_wr |=> !o_flash_req.valid;
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("launch accepted while busy");

endmodule : fsps_top

// ### rtl/fsps_regs.svh
`ifndef FSPS_REGS_SVH
`define FSPS_REGS_SVH

// Register selects on the software write port
`define FSPS_SEL_CTRL 2'h0
`define FSPS_SEL_UNLOCK 2'h1
`define FSPS_SEL_ADDR_HI 2'h2
`define FSPS_SEL_ADDR_LO 2'h3

// Control register fields
`define FSPS_CTRL_START_BIT 15
`define FSPS_CTRL_ERASE_BIT 0
`define FSPS_CTRL_RESET 16'h0000

// Unlock key values, written in this order
`define FSPS_KEY_FIRST 16'h0055
`define FSPS_KEY_SECOND 16'h00aa

// Address widths
`define FSPS_ADDR_HI_W 8
`define FSPS_ADDR_LO_W 16

`endif

// ### rtl/fsps_pkg.sv
package fsps_pkg;

    // Sequencer states, Gray coded along idle, issue, wait
    typedef enum logic [1:0] {
        FSPS_IDLE  = 2'b00,
        FSPS_ISSUE = 2'b01,
        FSPS_WAIT  = 2'b11
    } fsps_state_t;

    // Unlock progress
    typedef enum logic [1:0] {
        FSPS_KEY_NONE  = 2'b00,
        FSPS_KEY_HALF  = 2'b01,
        FSPS_KEY_ARMED = 2'b11
    } fsps_key_t;

    // Software register write
    typedef struct packed {
        logic wr_en;
        logic [1:0] sel;
        logic [15:0] data;
    } fsps_sw_wr_t;

    // Pair of instruction words to program
    typedef struct packed {
        logic [23:0] word1;
        logic [23:0] word0;
    } fsps_word_pair_t;

    // Request to the flash array
    typedef struct packed {
        logic valid;
        logic erase;
        logic [23:0] addr;
        fsps_word_pair_t words;
    } fsps_flash_req_t;

endpackage : fsps_pkg

// ### dv/fsps_flash_model.sv
`timescale 1ns/1ns
// ****************************************
// Flash array stand-in: answers each request with a one-cycle done after a set delay
// ****************************************
module fsps_flash_model
    import fsps_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire fsps_flash_req_t i_req,
    input wire logic [7:0] i_delay,
    output logic o_done
);
    logic [7:0] cnt_reg;
    logic busy_reg;

    // One operation at a time; done is a pulse, low whenever idle
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            busy_reg <= 1'b0;
            cnt_reg <= 8'h00;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_req.valid) begin
                busy_reg <= 1'b1;
                cnt_reg <= i_delay;
            end else if (busy_reg) begin
                if (cnt_reg == 8'h00) begin
                    o_done <= 1'b1;
                    busy_reg <= 1'b0;
                end else begin
                    cnt_reg <= cnt_reg - 8'h01;
                end
            end
        end
    end
endmodule : fsps_flash_model

// ### dv/fsps_top_bench.sv
`timescale 1ns/1ns
// ****************************************
// Bench for the self-program sequencer
// ****************************************
module fsps_top_bench;
    import fsps_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    fsps_sw_wr_t sw = '0;
    fsps_word_pair_t words = '0;
    logic done;
    logic [7:0] dly = 8'h05;
    fsps_flash_req_t req;
    logic stall;
    logic [15:0] ctrl;
    int errors = 0;
    int n_checks = 0;

    // 50 MHz clock
    always #10 clk = ~clk;

    fsps_top fsps_top_inst (.i_ref_clk(clk), .i_rst_b(rst_b), .i_sw_wr(sw), .i_prog_words(words),
        .i_flash_done(done), .o_flash_req(req), .o_core_stall(stall), .o_ctrl_rd(ctrl));
    fsps_flash_model fsps_flash_model_inst (.i_ref_clk(clk), .i_rst_b(rst_b), .i_req(req),
        .i_delay(dly), .o_done(done));

    task automatic chk(input logic [73:0] got, input logic [73:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One write, taken at the second edge, then released
    task automatic wr(input logic [1:0] sel, input logic [15:0] data);
        @(posedge clk);
        sw <= '{wr_en: 1'b1, sel: sel, data: data};
        @(posedge clk);
        sw <= '0;
    endtask : wr

    // Called while stalled, just after a control write edge; no writes go out until the array is done
    task automatic await_done();
        logic d;
        d = 1'b0;
        for (int i = 0; i < 300 && !d; i++) begin
            chk(stall, 1'b1);
            d = done;
            @(posedge clk);
            #1;
            if (i == 0) chk(req.valid, 1'b0);
        end
        chk({stall, ctrl[15]}, 2'b00);
    endtask : await_done

    // Address, key, control write; then judge the launch and the stall window
    // Key mode: 0 none, 1 proper, 2 bytes swapped, 3 first byte only
    task automatic launch(input logic [15:0] cw, input logic [23:0] a, input logic exp, input logic [1:0] unlk);
        wr(2'h2, {8'h00, a[23:16]});
        wr(2'h3, a[15:0]);
        if (unlk != 2'h0) wr(2'h1, (unlk == 2'h2) ? 16'h00aa : 16'h0055);
        if (unlk == 2'h1 || unlk == 2'h2) wr(2'h1, (unlk == 2'h2) ? 16'h0055 : 16'h00aa);
        wr(2'h0, cw);
        #1;
        chk(req.valid, exp);
        if (exp) begin
            chk({req.erase, req.addr}, {cw[0], a});
            if (!cw[0]) chk(req.words, words);
            chk(ctrl, cw);
            await_done();
        end else begin
            chk({stall, ctrl[15]}, 2'b00);
        end
    endtask : launch

    // Full sequence again while busy: control and address writes must be ignored
    task automatic busy_launch();
        dly <= 8'h28;
        wr(2'h2, 16'h0000);
        wr(2'h3, 16'h0006);
        wr(2'h1, 16'h0055);
        wr(2'h1, 16'h00aa);
        wr(2'h0, 16'h8000);
        #1;
        chk({req.valid, stall, ctrl}, {2'b11, 16'h8000});
        wr(2'h3, 16'h0002);
        wr(2'h1, 16'h0055);
        wr(2'h1, 16'h00aa);
        wr(2'h0, 16'h8001);
        #1;
        chk({req.valid, stall, ctrl}, {2'b01, 16'h8000});
        await_done();
        chk(ctrl, 16'h0000);
        dly <= 8'h05;
        wr(2'h1, 16'h0055);
        wr(2'h1, 16'h00aa);
        wr(2'h0, 16'h8000);
        #1;
        chk({req.valid, req.addr}, {1'b1, 24'h000006});
        await_done();
        $display("test busy done");
    endtask : busy_launch

    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    // Watchdog
    initial begin
        #200000;
        errors++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        chk({stall, ctrl}, 17'h0);
        words <= '{word1: 24'habcdef, word0: 24'h123456};
        launch(16'h8000, 24'h5a0002, 1'b1, 2'h1);
        $display("test program done");
        launch(16'h8001, 24'hc31400, 1'b1, 2'h1);
        $display("test erase done");
        launch(16'h8000, 24'h000002, 1'b0, 2'h0);
        wr(2'h1, 16'h0055);
        launch(16'h8001, 24'h000002, 1'b0, 2'h0);
        wr(2'h1, 16'h00aa);
        wr(2'h1, 16'h0055);
        launch(16'h8001, 24'h000002, 1'b0, 2'h2);
        launch(16'h8000, 24'h000002, 1'b0, 2'h3);
        $display("test refuse done");
        busy_launch();
        report_and_stop();
    end
endmodule : fsps_top_bench
